/* File: freq_seq_pkg.sv */
// Constants, widths and state encoding shared by the frequency sequencer files.
package freq_seq_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int FW  = 12;
  localparam int MVW = 12;
  localparam int UAW = 12;
  localparam int TW  = 18;
  localparam int DTW = 8;

  // ----------------------------------------------------------------
  // Clock and time figures
  // ----------------------------------------------------------------
  localparam int CLK_KHZ        = 20000;
  localparam int T_SS1_US       = 624;
  localparam int T_SS2_US       = 2500;
  localparam int T_SS3_US       = 3750;
  localparam int T_SS_ALL_US    = 7000;
  localparam int T_BM_ENTRY_US  = 10000;
  localparam int T_BURST_ON_US  = 10000;
  localparam int T_RISE_US      = 400;
  localparam int SS1_CYC        = T_SS1_US * CLK_KHZ / 1000;
  localparam int SS2_CYC        = T_SS2_US * CLK_KHZ / 1000;
  localparam int SS3_CYC        = T_SS3_US * CLK_KHZ / 1000;
  localparam int SS_ALL_CYC     = T_SS_ALL_US * CLK_KHZ / 1000;
  localparam int BM_ENTRY_CYC   = T_BM_ENTRY_US * CLK_KHZ / 1000;
  localparam int BURST_ON_CYC   = T_BURST_ON_US * CLK_KHZ / 1000;
  localparam int RISE_CYC       = T_RISE_US * CLK_KHZ / 1000;

  // ----------------------------------------------------------------
  // Frequency arithmetic
  // ----------------------------------------------------------------
  localparam logic [15:0] GAIN_KHZ_PER_MA = 16'h0190;
  localparam logic [15:0] UA_PER_MA       = 16'h03E8;
  localparam logic [15:0] SS0_MUL         = 16'h0004;
  localparam logic [15:0] SS1_MUL         = 16'h000D;
  localparam logic [15:0] SS1_DIV         = 16'h0005;
  localparam logic [15:0] BMF_MUL         = 16'h0004;
  localparam logic [15:0] BMF_DIV         = 16'h0003;
  localparam logic [15:0] SS_START_CAP    = 16'h0514;

  // ----------------------------------------------------------------
  // Pin levels in millivolts
  // ----------------------------------------------------------------
  localparam logic [MVW-1:0] BM_LOW_MV   = 12'h2EE;
  localparam logic [MVW-1:0] BM_RISE_MV  = 12'h7D0;
  localparam logic [MVW-1:0] BM_TOP_MV   = 12'h8CA;
  localparam logic [MVW-1:0] BM_STEP_MV  = 12'h064;
  localparam logic [MVW-1:0] RF_HOLD_MV  = 12'h9C4;

  // ----------------------------------------------------------------
  // Sweep step intervals in cycles and misc counts
  // ----------------------------------------------------------------
  localparam logic [7:0]     STEP_SS1    = 8'h07;
  localparam logic [7:0]     STEP_SS2    = 8'h1F;
  localparam logic [7:0]     STEP_SS3    = 8'h2F;
  localparam logic [7:0]     STEP_SOFT   = 8'h03;
  localparam logic [7:0]     STEP_PL     = 8'h0F;
  localparam logic [DTW-1:0] DT_MAX      = 8'hFF;
  localparam logic [3:0]     LOAD_CYCLES = 4'h8;

  typedef enum logic [3:0] {
    ST_WAIT_BUS, ST_SS1, ST_SS2, ST_SS3, ST_RUN,
    ST_SOFT_OFF, ST_SLEEP, ST_SOFT_ON, ST_PLIMIT
  } state_t;

endpackage : freq_seq_pkg

/* File: pin_sync.sv */
// Two-flip-flop synchroniser for a group of comparator pins.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule : pin_sync
`default_nettype wire

/* File: interval_timer.sv */
// Saturating up-counter that measures time since its last clear.
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
  parameter int W = 18
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control and count
  input  wire logic         clear,
  output var  logic [W-1:0] count
);

  logic [W-1:0] count_nxt;

  always_comb begin
    if (clear) begin
      count_nxt = '0;
    end else if (&count) begin
      count_nxt = count;
    end else begin
      count_nxt = count + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= count_nxt;
    end
  end

endmodule : interval_timer
`default_nettype wire

/* File: resonant_bridge_freq_sequencer.sv */
// Half-bridge frequency sequencer: soft-start, regulation, burst operation, dead time.
`timescale 1ns/1ps
`default_nettype none
module resonant_bridge_freq_sequencer #(
  parameter int SS1_CYCLES      = freq_seq_pkg::SS1_CYC,
  parameter int SS2_CYCLES      = freq_seq_pkg::SS2_CYC,
  parameter int SS3_CYCLES      = freq_seq_pkg::SS3_CYC,
  parameter int SS_ALL_CYCLES   = freq_seq_pkg::SS_ALL_CYC,
  parameter int BM_ENTRY_CYCLES = freq_seq_pkg::BM_ENTRY_CYC,
  parameter int BURST_ON_CYCLES = freq_seq_pkg::BURST_ON_CYC,
  parameter int RISE_CYCLES     = freq_seq_pkg::RISE_CYC
) (
  // Clock and reset
  input  wire logic                          SYS_CLK,
  input  wire logic                          ARST_N,
  // Comparator pins
  input  wire logic                          BUS_VOLTAGE_SENSE_OK,
  input  wire logic                          LOWSIDE_CURRENT_SENSE_OVER,
  input  wire logic                          LOWSIDE_CURRENT_SENSE_NEG,
  input  wire logic                          OPTO_BALANCED,
  input  wire logic                          HIGH_SIDE_SWITCH_GATE,
  // Converter and trim values on the system clock
  input  wire logic [freq_seq_pkg::UAW-1:0]  FREQ_SETTING_PIN_UA,
  input  wire logic [freq_seq_pkg::MVW-1:0]  BURST_PIN_MV,
  input  wire logic [freq_seq_pkg::FW-1:0]   LOWEST_RUN_FREQUENCY,
  input  wire logic [freq_seq_pkg::FW-1:0]   HIGHEST_RUN_FREQUENCY,
  input  wire logic [freq_seq_pkg::FW-1:0]   POWER_LIMIT_FREQUENCY,
  // Frequency and stage control
  output var  logic [freq_seq_pkg::FW-1:0]   FREQ_KHZ,
  output var  logic                          HB_RUN,
  output var  logic                          PFC_RUN,
  output var  logic                          BURST_CLAMP_EN,
  output var  logic [freq_seq_pkg::MVW-1:0]  BURST_CLAMP_MV,
  output var  logic [freq_seq_pkg::MVW-1:0]  FREQ_SETTING_PIN_MV,
  output var  logic                          SOFT_START_ACTIVE,
  output var  logic                          BURST_OPERATION,
  output var  logic [freq_seq_pkg::DTW-1:0]  DEAD_TIME_CYC
);
  import freq_seq_pkg::*;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisation
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  logic [4:0] pins_s;
  logic       bus_ok;
  logic       cs_over;
  logic       cs_neg;
  logic       opto_bal;
  logic       hs_gate;

  pin_sync #(.W(5)) u_pin_sync (
    .clk   (SYS_CLK),
    .rst_n (rst_n),
    .d     ({BUS_VOLTAGE_SENSE_OK, LOWSIDE_CURRENT_SENSE_OVER, LOWSIDE_CURRENT_SENSE_NEG,
             OPTO_BALANCED, HIGH_SIDE_SWITCH_GATE}),
    .q     (pins_s)
  );

  assign {bus_ok, cs_over, cs_neg, opto_bal, hs_gate} = pins_s;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  localparam logic [TW-1:0] SS1_LIM   = TW'(SS1_CYCLES);
  localparam logic [TW-1:0] SS2_LIM   = TW'(SS2_CYCLES);
  localparam logic [TW-1:0] SS3_LIM   = TW'(SS3_CYCLES);
  localparam logic [TW-1:0] SSALL_LIM = TW'(SS_ALL_CYCLES);
  localparam logic [TW-1:0] ENTRY_LIM = TW'(BM_ENTRY_CYCLES);
  localparam logic [TW-1:0] ON_LIM    = TW'(BURST_ON_CYCLES);
  localparam logic [TW-1:0] RISE_LIM  = TW'(RISE_CYCLES);

  state_t        state_r;
  state_t        state_nxt;
  logic [TW-1:0] t_state;
  logic [TW-1:0] t_ss_all;
  logic [TW-1:0] t_bm_low;
  logic [TW-1:0] t_rise;
  logic [TW-1:0] t_on;

  interval_timer #(.W(TW)) u_t_state (
    .clk   (SYS_CLK),
    .rst_n (rst_n),
    .clear (state_nxt != state_r),
    .count (t_state)
  );

  interval_timer #(.W(TW)) u_t_ss_all (
    .clk   (SYS_CLK),
    .rst_n (rst_n),
    .clear (state_r == ST_WAIT_BUS),
    .count (t_ss_all)
  );

  interval_timer #(.W(TW)) u_t_bm_low (
    .clk   (SYS_CLK),
    .rst_n (rst_n),
    .clear ((state_r != ST_RUN) || (BURST_PIN_MV >= BM_LOW_MV)),
    .count (t_bm_low)
  );

  interval_timer #(.W(TW)) u_t_rise (
    .clk   (SYS_CLK),
    .rst_n (rst_n),
    .clear (BURST_PIN_MV < BM_RISE_MV),
    .count (t_rise)
  );

  interval_timer #(.W(TW)) u_t_on (
    .clk   (SYS_CLK),
    .rst_n (rst_n),
    .clear (state_r == ST_SLEEP),
    .count (t_on)
  );

  // ----------------------------------------------------------------
  // Frequency targets
  // ----------------------------------------------------------------
  logic [15:0]   low16;
  logic [15:0]   span16;
  logic [15:0]   ss0_raw;
  logic [FW-1:0] f_ss0;
  logic [FW-1:0] f_ss1;
  logic [FW-1:0] f_bm;
  logic [FW-1:0] f_cco;
  logic [FW-1:0] f_high;
  logic [FW-1:0] f_low;
  logic [FW-1:0] f_pl;
  logic [31:0]   cco_prod;

  always_comb begin
    f_high  = HIGHEST_RUN_FREQUENCY;
    f_low   = LOWEST_RUN_FREQUENCY;
    f_pl    = POWER_LIMIT_FREQUENCY;
    low16   = {4'h0, f_low};
    span16  = {4'h0, f_high} - low16;
    ss0_raw = 16'(span16 * SS0_MUL) + low16;
    f_ss0   = (ss0_raw > SS_START_CAP) ? FW'(SS_START_CAP) : FW'(ss0_raw);
    f_ss1   = FW'(16'(span16 * SS1_MUL) / SS1_DIV + low16);
    f_bm    = FW'(16'(span16 * BMF_MUL) / BMF_DIV + low16);
    // The pin current already sums burst, opto and fixed resistor parts.
    cco_prod = {20'h00000, FREQ_SETTING_PIN_UA} * {16'h0000, GAIN_KHZ_PER_MA};
    f_cco   = FW'(cco_prod / {16'h0000, UA_PER_MA});
  end

  // ----------------------------------------------------------------
  // Load step history over switching cycles
  // ----------------------------------------------------------------
  logic [MVW-1:0] hist_r [0:7];
  logic [MVW-1:0] hist_nxt [0:7];
  logic [2:0]     hist_idx_r;
  logic [2:0]     hist_idx_nxt;
  logic [3:0]     hist_fill_r;
  logic [3:0]     hist_fill_nxt;
  logic           hs_d_r;
  logic           hs_fall;
  logic           load_step;

  always_comb begin
    hs_fall       = hs_d_r & ~hs_gate;
    hist_nxt      = hist_r;
    hist_idx_nxt  = hist_idx_r;
    hist_fill_nxt = hist_fill_r;
    load_step     = (hist_fill_r == LOAD_CYCLES) && (BURST_PIN_MV > hist_r[hist_idx_r])
                    && ((BURST_PIN_MV - hist_r[hist_idx_r]) >= BM_STEP_MV);
    if (state_r != ST_PLIMIT) begin
      hist_idx_nxt  = 3'h0;
      hist_fill_nxt = 4'h0;
    end else if (hs_fall) begin
      hist_nxt[hist_idx_r] = BURST_PIN_MV;
      hist_idx_nxt         = hist_idx_r + 3'h1;
      if (hist_fill_r != LOAD_CYCLES) begin
        hist_fill_nxt = hist_fill_r + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [FW-1:0]  freq_nxt;
  logic [MVW-1:0] clamp_mv_nxt;
  logic           clamp_en_nxt;
  logic           hb_nxt;
  logic           pfc_nxt;
  logic [7:0]     step_cnt_r;
  logic [7:0]     step_cnt_nxt;
  logic [7:0]     step_len;
  logic           step;
  logic [TW-1:0]  off_len_r;
  logic [TW-1:0]  off_len_nxt;

  always_comb begin
    state_nxt    = state_r;
    freq_nxt     = FREQ_KHZ;
    clamp_mv_nxt = BURST_CLAMP_MV;
    clamp_en_nxt = BURST_CLAMP_EN;
    hb_nxt       = HB_RUN;
    pfc_nxt      = PFC_RUN;
    off_len_nxt  = off_len_r;
    step         = (step_cnt_r == 8'h00);
    case (state_r)
      ST_SS1:  step_len = STEP_SS1;
      ST_SS2:  step_len = STEP_SS2;
      ST_SS3:  step_len = STEP_SS3;
      ST_PLIMIT: step_len = STEP_PL;
      default: step_len = STEP_SOFT;
    endcase
    step_cnt_nxt = step ? step_len : step_cnt_r - 8'h01;
    case (state_r)
      ST_WAIT_BUS: begin
        hb_nxt   = 1'b0;
        freq_nxt = f_ss0;
        if (bus_ok) begin
          state_nxt    = ST_SS1;
          hb_nxt       = 1'b1;
          pfc_nxt      = 1'b1;
          clamp_en_nxt = 1'b1;
          clamp_mv_nxt = BM_LOW_MV;
        end
      end
      ST_SS1: begin
        if (step && !cs_over && (FREQ_KHZ > f_ss1)) begin
          freq_nxt = FREQ_KHZ - FW'(1);
        end
        if ((FREQ_KHZ <= f_ss1) || (t_state >= SS1_LIM)) begin
          state_nxt = ST_SS2;
        end
      end
      ST_SS2: begin
        if (step && !cs_over && (FREQ_KHZ > f_high)) begin
          freq_nxt = FREQ_KHZ - FW'(1);
        end
        if ((FREQ_KHZ <= f_high) || (t_state >= SS2_LIM)) begin
          state_nxt = ST_SS3;
        end
      end
      ST_SS3: begin
        if (step && !cs_over) begin
          if (FREQ_KHZ > f_low) begin
            freq_nxt = FREQ_KHZ - FW'(1);
          end
          if (BURST_CLAMP_MV < BM_TOP_MV) begin
            clamp_mv_nxt = BURST_CLAMP_MV + MVW'(1);
          end
        end
        if (opto_bal || (FREQ_KHZ <= f_low) || (t_state >= SS3_LIM)) begin
          state_nxt    = ST_RUN;
          clamp_en_nxt = 1'b0;
        end
      end
      ST_RUN: begin
        freq_nxt = (f_cco > f_high) ? f_high : f_cco;
        if (t_bm_low >= ENTRY_LIM) begin
          state_nxt = ST_SOFT_OFF;
          freq_nxt  = f_high;
        end
      end
      ST_SOFT_OFF: begin
        if (step && (FREQ_KHZ < f_bm)) begin
          freq_nxt = FREQ_KHZ + FW'(1);
        end
        if (FREQ_KHZ >= f_bm) begin
          state_nxt = ST_SLEEP;
          hb_nxt    = 1'b0;
          pfc_nxt   = 1'b0;
        end
      end
      ST_SLEEP: begin
        if (BURST_PIN_MV >= BM_TOP_MV) begin
          off_len_nxt = t_state;
          hb_nxt      = 1'b1;
          pfc_nxt     = 1'b1;
          if (t_rise <= RISE_LIM) begin
            state_nxt = ST_RUN;
            freq_nxt  = f_high;
          end else begin
            state_nxt = ST_SOFT_ON;
            freq_nxt  = f_bm;
          end
        end
      end
      ST_SOFT_ON: begin
        if (step && (FREQ_KHZ > f_pl)) begin
          freq_nxt = FREQ_KHZ - FW'(1);
        end
        if (opto_bal) begin
          state_nxt = ST_SOFT_OFF;
        end else if (FREQ_KHZ <= f_pl) begin
          state_nxt = ST_PLIMIT;
        end
      end
      ST_PLIMIT: begin
        if (step && (FREQ_KHZ > f_pl)) begin
          freq_nxt = FREQ_KHZ - FW'(1);
        end else if (step && (FREQ_KHZ < f_pl)) begin
          freq_nxt = FREQ_KHZ + FW'(1);
        end
        if (load_step || (t_on >= ON_LIM)
            || ({1'b0, t_on} > {off_len_r, 1'b0})) begin
          state_nxt = ST_RUN;
        end else if (opto_bal) begin
          state_nxt = ST_SOFT_OFF;
        end
      end
      default: begin
        state_nxt = ST_WAIT_BUS;
      end
    endcase
    if ((state_r == ST_SS1 || state_r == ST_SS2 || state_r == ST_SS3)
        && (t_ss_all >= SSALL_LIM)) begin
      state_nxt    = ST_RUN;
      clamp_en_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Dead time measurement
  // ----------------------------------------------------------------
  logic [DTW-1:0] dt_cnt_r;
  logic [DTW-1:0] dt_cnt_nxt;
  logic           dt_busy_r;
  logic           dt_busy_nxt;
  logic [DTW-1:0] dead_nxt;

  always_comb begin
    dt_cnt_nxt  = dt_cnt_r;
    dt_busy_nxt = dt_busy_r;
    dead_nxt    = DEAD_TIME_CYC;
    if (hs_fall) begin
      dt_cnt_nxt  = '0;
      dt_busy_nxt = 1'b1;
    end else if (dt_busy_r) begin
      if (cs_neg || (dt_cnt_r == DT_MAX)) begin
        dead_nxt    = dt_cnt_r;
        dt_busy_nxt = 1'b0;
      end else begin
        dt_cnt_nxt = dt_cnt_r + DTW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r             <= ST_WAIT_BUS;
      FREQ_KHZ            <= '0;
      BURST_CLAMP_MV      <= '0;
      BURST_CLAMP_EN      <= 1'b0;
      HB_RUN              <= 1'b0;
      PFC_RUN             <= 1'b0;
      FREQ_SETTING_PIN_MV <= '0;
      SOFT_START_ACTIVE   <= 1'b0;
      BURST_OPERATION     <= 1'b0;
      DEAD_TIME_CYC       <= '0;
      step_cnt_r          <= '0;
      off_len_r           <= '0;
      dt_cnt_r            <= '0;
      dt_busy_r           <= 1'b0;
      hs_d_r              <= 1'b0;
      hist_idx_r          <= '0;
      hist_fill_r         <= '0;
      for (int i = 0; i < 8; i++) begin
        hist_r[i] <= '0;
      end
    end else begin
      state_r             <= state_nxt;
      FREQ_KHZ            <= freq_nxt;
      BURST_CLAMP_MV      <= clamp_mv_nxt;
      BURST_CLAMP_EN      <= clamp_en_nxt;
      HB_RUN              <= hb_nxt;
      PFC_RUN             <= pfc_nxt;
      FREQ_SETTING_PIN_MV <= RF_HOLD_MV;
      SOFT_START_ACTIVE   <= (state_nxt == ST_SS1) || (state_nxt == ST_SS2)
                             || (state_nxt == ST_SS3);
      BURST_OPERATION     <= (state_nxt == ST_SOFT_OFF) || (state_nxt == ST_SLEEP)
                             || (state_nxt == ST_SOFT_ON) || (state_nxt == ST_PLIMIT);
      DEAD_TIME_CYC       <= dead_nxt;
      step_cnt_r          <= step_cnt_nxt;
      off_len_r           <= off_len_nxt;
      dt_cnt_r            <= dt_cnt_nxt;
      dt_busy_r           <= dt_busy_nxt;
      hs_d_r              <= hs_gate;
      hist_idx_r          <= hist_idx_nxt;
      hist_fill_r         <= hist_fill_nxt;
      hist_r              <= hist_nxt;
    end
  end

endmodule : resonant_bridge_freq_sequencer
`default_nettype wire

/* File: freq_seq_sva.sv */
// Concurrent checks on the frequency sequencer ports.
`timescale 1ns/1ps
`default_nettype none
module freq_seq_sva (
  input wire logic SYS_CLK, ARST_N, BUS_VOLTAGE_SENSE_OK, LOWSIDE_CURRENT_SENSE_OVER,
  input wire logic HB_RUN, PFC_RUN, BURST_CLAMP_EN, SOFT_START_ACTIVE, BURST_OPERATION,
  input wire logic [11:0] FREQ_KHZ, BURST_CLAMP_MV, FREQ_SETTING_PIN_MV
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  sequence over_held;
    LOWSIDE_CURRENT_SENSE_OVER [*4];
  endsequence
  sequence in_sweep;
    SOFT_START_ACTIVE && $past(SOFT_START_ACTIVE);
  endsequence
  chk_bus_gate: assert property ($rose(SOFT_START_ACTIVE) |-> $past(BUS_VOLTAGE_SENSE_OK, 3))
    else $error("sweep began without bus");
  chk_start_cap: assert property ($rose(SOFT_START_ACTIVE) |-> FREQ_KHZ <= 12'h514)
    else $error("sweep start above cap");
  chk_sweep_down: assert property (in_sweep |-> FREQ_KHZ <= $past(FREQ_KHZ))
    else $error("sweep rose");
  chk_sweep_pause: assert property (over_held ##0 in_sweep |-> $stable(FREQ_KHZ))
    else $error("sweep not paused");
  chk_clamp_range: assert property (BURST_CLAMP_EN |-> BURST_CLAMP_MV inside {[12'h2EE:12'h8CA]})
    else $error("clamp level out of range");
  chk_rf_hold: assert property (HB_RUN |-> FREQ_SETTING_PIN_MV == 12'h9C4)
    else $error("freq pin level");
  chk_sleep_stops: assert property (BURST_OPERATION && !HB_RUN |-> !PFC_RUN)
    else $error("sleep left pfc running");
  chk_clamp_off: assert property (!SOFT_START_ACTIVE |-> !BURST_CLAMP_EN)
    else $error("clamp held outside sweep");
endmodule : freq_seq_sva
bind resonant_bridge_freq_sequencer freq_seq_sva freq_seq_sva_i (.SYS_CLK(SYS_CLK),
  .ARST_N(ARST_N), .BUS_VOLTAGE_SENSE_OK(BUS_VOLTAGE_SENSE_OK), .HB_RUN(HB_RUN),
  .LOWSIDE_CURRENT_SENSE_OVER(LOWSIDE_CURRENT_SENSE_OVER), .PFC_RUN(PFC_RUN),
  .BURST_CLAMP_EN(BURST_CLAMP_EN), .SOFT_START_ACTIVE(SOFT_START_ACTIVE),
  .BURST_OPERATION(BURST_OPERATION), .FREQ_KHZ(FREQ_KHZ), .BURST_CLAMP_MV(BURST_CLAMP_MV),
  .FREQ_SETTING_PIN_MV(FREQ_SETTING_PIN_MV));
`default_nettype wire

/* File: hb_tank_model.sv */
// Behavioural half-bridge: high-side gate and negative current sense.
`timescale 1ns/1ps
`default_nettype none
module hb_tank_model #(
  parameter int DT = 6
) (
  input  wire logic clk,
  input  wire logic run,
  output var  logic hs_gate = 1'b0,
  output var  logic sense_neg = 1'b0
);
  logic [4:0] ph = 5'h00;
  // The sense swings negative DT cycles after high-side turn-off.
  always @(posedge clk) begin
    ph <= (ph == 5'h13) ? 5'h00 : ph + 5'h01;
    hs_gate <= run && ph < 5'h0A;
    sense_neg <= run && ph >= 5'h0A + 5'(DT);
  end
endmodule : hb_tank_model
`default_nettype wire

/* File: resonant_bridge_freq_sequencer_tb.sv */
// Self-checking testbench for the frequency sequencer.
`timescale 1ns/1ps
`default_nettype none
module resonant_bridge_freq_sequencer_tb;
  import freq_seq_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, bus_ok = 1'b0, over = 1'b0, opto = 1'b0;
  logic hs, neg, hb, pfc, cl_en, ss, bop;
  logic [11:0] ua = 12'h3E8, bm = 12'h8CA, cl_mv, rf_mv, fq, f0;
  logic [11:0] lo_f = 12'h064, hi_f = 12'h1F4, pl_f = 12'h1C2;
  logic [7:0] dead;
  int n_errors = 0;
  int total_checks = 0;
  always #25 clk = ~clk;
  resonant_bridge_freq_sequencer #(.SS2_CYCLES(80), .SS3_CYCLES(120),
    .BM_ENTRY_CYCLES(50), .BURST_ON_CYCLES(200), .RISE_CYCLES(20))
  resonant_bridge_freq_sequencer_i (.SYS_CLK(clk), .ARST_N(arst_n),
    .BUS_VOLTAGE_SENSE_OK(bus_ok), .LOWSIDE_CURRENT_SENSE_OVER(over),
    .LOWSIDE_CURRENT_SENSE_NEG(neg), .OPTO_BALANCED(opto), .HIGH_SIDE_SWITCH_GATE(hs),
    .FREQ_SETTING_PIN_UA(ua), .BURST_PIN_MV(bm), .LOWEST_RUN_FREQUENCY(lo_f),
    .HIGHEST_RUN_FREQUENCY(hi_f), .POWER_LIMIT_FREQUENCY(pl_f), .FREQ_KHZ(fq),
    .HB_RUN(hb), .PFC_RUN(pfc), .BURST_CLAMP_EN(cl_en), .BURST_CLAMP_MV(cl_mv),
    .FREQ_SETTING_PIN_MV(rf_mv), .SOFT_START_ACTIVE(ss), .BURST_OPERATION(bop),
    .DEAD_TIME_CYC(dead));
  hb_tank_model hb_tank_model_i (.clk(clk), .run(hb), .hs_gate(hs), .sense_neg(neg));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk1(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk1
  task automatic chkv(input logic [11:0] got, input logic [11:0] exp, input string m);
    chk1(got === exp, 1'b1, m);
  endtask : chkv
  task automatic wait_on(ref logic s, input logic v, input int lim);
    for (int k = 0; k < lim && s !== v; k++) step(1);
  endtask : wait_on
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic t_power_up;
    step(10);
    chk1(hb, 1'b0, "ran early");
    bus_ok = 1'b1;
    step(3);
    chk1(hb & cl_en & pfc, 1'b1, "no start");
    chkv(cl_mv, 12'h2EE, "clamp");
    chkv(fq, 12'h514, "start cap");
    chkv(rf_mv, 12'h9C4, "rf hold");
    over = 1'b1;
    step(4);
    f0 = fq;
    step(16);
    chkv(fq, f0, "no pause");
    over = 1'b0;
    step(40);
    chk1(fq < f0, 1'b1, "no resume");
    chk1(dead >= 8'h05 && dead <= 8'h07, 1'b1, "dead time");
    $display("power-up done");
  endtask : t_power_up
  task automatic t_sweep_run;
    wait_on(ss, 1'b0, 2000);
    chk1(ss | cl_en, 1'b0, "sweep end");
    step(2);
    chkv(fq, 12'h190, "gain");
    ua = 12'h7D0;
    step(2);
    chkv(fq, 12'h1F4, "highest");
    ua = 12'h3E8;
    $display("sweep done");
  endtask : t_sweep_run
  task automatic t_burst_cycle;
    bm = 12'h1F4;
    step(40);
    chk1(bop, 1'b0, "early entry");
    wait_on(bop, 1'b1, 30);
    chk1(bop, 1'b1, "no entry");
    wait_on(hb, 1'b0, 800);
    chk1(hb | pfc, 1'b0, "no sleep");
    step(100);
    bm = 12'h7D0;
    step(30);
    bm = 12'h8CA;
    wait_on(hb, 1'b1, 10);
    chkv(fq, 12'h279, "wake freq");
    chk1(pfc, 1'b1, "pfc asleep");
    wait_on(bop, 1'b0, 1500);
    chk1(bop | ss | ~hb, 1'b0, "no exit");
    step(2);
    chkv(fq, 12'h190, "run after exit");
    $display("burst done");
  endtask : t_burst_cycle
  task automatic t_fast_exit;
    bm = 12'h1F4;
    wait_on(hb, 1'b0, 900);
    bm = 12'h7D0;
    step(30);
    bm = 12'h8CA;
    wait_on(hb, 1'b1, 10);
    bm = 12'h1F4;
    opto = 1'b1;
    wait_on(hb, 1'b0, 40);
    chk1(bop & ~hb & ~pfc, 1'b1, "no burst-off");
    opto = 1'b0;
    step(20);
    bm = 12'h834;
    step(5);
    bm = 12'h8CA;
    step(4);
    chk1(~bop & hb, 1'b1, "fast exit");
    $display("fast exit done");
  endtask : t_fast_exit
  initial begin
    step(20);
    arst_n = 1'b1;
    t_power_up;
    t_sweep_run;
    t_burst_cycle;
    t_fast_exit;
    stop_test;
  end
  initial begin
    #(10000 * 50);
    n_errors++;
    stop_test;
  end
endmodule : resonant_bridge_freq_sequencer_tb
`default_nettype wire
